/* core/dcpm_pkg.sv */
// shared constants and types for the converter control port and its host
package dcpm_pkg;

  // ----------------------------------------------------------------
  // chip addressing and register map of the device
  // ----------------------------------------------------------------
  localparam logic [6:0] SPI_CHIP_ADDR = 7'h10;
  localparam logic [4:0] I2C_ADDR_HI = 5'h04;
  localparam logic [7:0] PTR_RESET = 8'h01;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [2:0] MODE_REG_IDX = 3'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int PTR_AUTO_INCREMENT_BIT = 7;
  localparam int CAL_BIT = 7;
  localparam int MUTE_BIT = 6;
  localparam int MODE_MSB = 5;
  localparam int MODE_LSB = 1;
  localparam int PDN_BIT = 0;

  // ----------------------------------------------------------------
  // mode decoding
  // ----------------------------------------------------------------
  localparam logic [1:0] DEEMPH_OFF = 2'h3;
  localparam logic [2:0] DOUBLE_CODE = 3'h7;
  localparam logic [2:0] QUAD_CODE = 3'h6;

  typedef enum logic [1:0] {
    SPD_SINGLE = 2'b00,
    SPD_DOUBLE = 2'b01,
    SPD_QUAD = 2'b10
  } dcpm_speed_e;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_PTR = 3'b010,
    D_WR = 3'b011,
    D_RD = 3'b100,
    D_ACK = 3'b101,
    D_RACK = 3'b110,
    D_SKIP = 3'b111
  } dcpm_dst_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BITS = 2'b10,
    H_STOP = 2'b11
  } dcpm_hst_e;

  // ----------------------------------------------------------------
  // host controller registers (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PTR_OFF = 8'h04;
  localparam logic [7:0] WDAT_OFF = 8'h08;
  localparam logic [7:0] RDAT_OFF = 8'h0c;
  localparam logic [7:0] STAT_OFF = 8'h10;
  localparam int GO_BIT = 0;
  localparam int RD_BIT = 1;
  localparam int SPI_BIT = 2;
  localparam int STRAP0_BIT = 3;
  localparam int STRAP1_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // ----------------------------------------------------------------
  // link timing and frame shapes
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int LINK_NS = 160;
  localparam int HALF_CYC = LINK_NS / (2 * CLK_NS);
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
  localparam int FRAME_W = 27;
  localparam logic [4:0] NBIT_I2C_WR = 5'h1b;
  localparam logic [4:0] NBIT_I2C_RD = 5'h12;
  localparam logic [4:0] NBIT_SPI_WR = 5'h18;
  localparam logic [4:0] NBIT_SPI_RD = 5'h10;
  localparam logic [26:0] ACKM_I2C_WR = 27'h0040201;
  localparam logic [26:0] ACKM_I2C_RD = 27'h0040000;
  localparam logic [1:0] STOP_LAST = 2'h2;

endpackage : dcpm_pkg

/* core/dcpm_if.sv */
// control link between the converter control port and its host
`timescale 1ns/10ps

interface dcpm_if;
  logic bit_clk;
  logic sel;
  logic ctl_in;
  logic dev_sd_o;
  logic dev_sd_oe;
  logic host_sd_o;
  logic host_sd_oe;
  logic sd_level;

  // pulled-up shared data line; any enabled low driver wins
  assign sd_level = ~((dev_sd_oe & ~dev_sd_o) | (host_sd_oe & ~host_sd_o));

  modport dev (
    input bit_clk,
    input sel,
    input ctl_in,
    input sd_level,
    output dev_sd_o,
    output dev_sd_oe
  );

  modport host (
    output bit_clk,
    output sel,
    output ctl_in,
    output host_sd_o,
    output host_sd_oe,
    input sd_level
  );
endinterface : dcpm_if

/* core/dcpm_sync.sv */
// two-flop synchroniser with one extra stage for edge finding
`timescale 1ns/10ps

module dcpm_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] q_d
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] qd_ff;

  // reset low so a released strap only ever shows a rising edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff <= '0;
      q_ff <= '0;
      qd_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
      qd_ff <= q_ff;
    end
  end

  assign q = q_ff;
  assign q_d = qd_ff;
endmodule : dcpm_sync

/* core/dcpm_device.sv */
// converter control port, register file and mode selection
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/10ps

// Overview of operation
// [R1] mute indicator low on init, reset, mute, sleep, bad ratio
// [R2] select falling edge latches SPI until reset/sleep
// [R3] I2C answers only when address matches strap pins
// [R4] SPI samples data on rising bit clock
// [R5] SPI frame: chip address 0010000, rw, pointer, data
// [R6] SPI write pointer is 01h; data lands there
// [R7] I2C address is 00100 then high strap, low strap
// [R8] I2C eighth address bit: one read, zero write
// [R9] I2C write: pointer byte then data bytes stored
// [R10] I2C read returns pointed register after address
// [R11] pointer byte: increment bit7, zeros, index 2:0
// [R12] device is slave only; drives shared data pin
// [R13] host grounds mode pin 1 in control mode
// [R14] single speed: low two pins pick format
// [R15] single speed: pins 3:2 pick de-emphasis
// [R16] mode pins 4:2 at 111 select double speed
// [R17] mode pins 4:2 at 110 select quad speed
// [R18] port select high: settings from control register
// [R19] host holds reset until audio clocks stable
// [R20] port runs asynchronously; host keeps pins still
// [R21] port select low: settings from mode pins
// [R22] mode register: cal, mute, mode 4:0, sleep
// [R23] auto increment advances pointer after each byte
module dcpm_device (
  input wire logic hclk,
  input wire logic hresetn,
  dcpm_if.dev lnk,
  input wire logic port_select,
  input wire logic [4:0] mode_pins,
  input wire logic mute_req,
  input wire logic init_busy,
  input wire logic ratio_bad,
  input wire logic cal_done,
  output logic [1:0] format_sel,
  output logic [1:0] deemph_sel,
  output dcpm_pkg::dcpm_speed_e speed,
  output logic mute_indicator_out,
  output logic cal_start,
  output logic mute_active,
  output logic sleep_active,
  output logic spi_mode
);
  import dcpm_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisation and edge finding
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;
  logic [3:0] pin_lvl_d;

  assign pin_raw = {lnk.sd_level, lnk.ctl_in, lnk.sel, lnk.bit_clk};

  // audio clocks are unrelated to the port, so all four link pins are resynced
  dcpm_sync #(.W(4)) u_sync ( // R20
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pin_raw),
    .q(pin_lvl),
    .q_d(pin_lvl_d)
  );

  wire clk_lvl = pin_lvl[0];
  wire clk_rise = pin_lvl[0] & ~pin_lvl_d[0];
  wire clk_fall = ~pin_lvl[0] & pin_lvl_d[0];
  wire sel_lvl = pin_lvl[1];
  wire sel_fall = ~pin_lvl[1] & pin_lvl_d[1];
  wire sel_rise = pin_lvl[1] & ~pin_lvl_d[1];
  wire cin_lvl = pin_lvl[2];
  wire sda_lvl = pin_lvl[3];
  wire sda_fall = ~pin_lvl[3] & pin_lvl_d[3];
  wire sda_rise = pin_lvl[3] & ~pin_lvl_d[3];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dcpm_dst_e state_ff;
  dcpm_dst_e nxt_state;
  dcpm_dst_e after_ff;
  dcpm_dst_e nxt_after;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic out_ff;
  logic nxt_out;
  logic oe_ff;
  logic nxt_oe;
  logic spi_ff;
  logic mutei_ff;
  logic [1:0] fmt_ff;
  logic [1:0] dem_ff;
  dcpm_speed_e spd_ff;

  function automatic logic [7:0] reg_at(input logic [7:0] p,
                                        input logic [7:0] m);
    reg_at = (p[2:0] == MODE_REG_IDX) ? m : 8'h00;
  endfunction : reg_at

  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    ptr_next = p;
    if (p[PTR_AUTO_INCREMENT_BIT])
      ptr_next[2:0] = p[2:0] + 3'h1;
  endfunction : ptr_next

  // ----------------------------------------------------------------
  // serial decode
  // ----------------------------------------------------------------
  wire bit_in = spi_ff ? cin_lvl : sda_lvl;
  wire i2c_start = ~spi_ff & sda_fall & clk_lvl;
  wire i2c_stop = ~spi_ff & sda_rise & clk_lvl;
  wire sample = port_select & clk_rise & (~spi_ff | ~sel_lvl); // R4
  wire drive_edge = port_select & clk_fall;
  wire [7:0] byte_in = {sh_ff[6:0], bit_in};
  wire byte_last = (cnt_ff == BIT_LAST);
  wire [6:0] i2c_addr = {I2C_ADDR_HI, cin_lvl, sel_lvl}; // R7
  wire addr_ok = spi_ff ? (byte_in[7:1] == SPI_CHIP_ADDR) // R5
                        : (byte_in[7:1] == i2c_addr); // R3
  wire [7:0] ptr_wr = {byte_in[PTR_AUTO_INCREMENT_BIT], 4'h0, byte_in[2:0]}; // R11
  wire pdn_rise = nxt_mode[PDN_BIT] & ~mode_ff[PDN_BIT];

  always_comb
  begin
    logic go;
    dcpm_dst_e tgt;
    go = 1'b0;
    tgt = D_IDLE;
    nxt_state = state_ff;
    nxt_after = after_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_mode = mode_ff;
    nxt_out = out_ff;
    nxt_oe = oe_ff;
    if (cal_done)
      nxt_mode[CAL_BIT] = 1'b0;
    if (!port_select)
    begin
      nxt_state = D_IDLE;
      nxt_oe = 1'b0;
    end
    else if (i2c_start || sel_fall)
    begin
      nxt_state = D_ADDR;
      nxt_cnt = 3'h0;
      nxt_out = 1'b0;
      nxt_oe = sel_fall; // R12
    end
    else if (i2c_stop || (spi_ff && sel_rise))
    begin
      nxt_state = D_IDLE;
      nxt_oe = 1'b0;
    end
    else if (sample)
    begin
      nxt_cnt = cnt_ff + 3'h1;
      unique case (state_ff)
        D_IDLE, D_SKIP: nxt_cnt = cnt_ff;
        D_ADDR:
        begin
          nxt_sh = byte_in;
          if (byte_last)
          begin
            go = addr_ok;
            tgt = bit_in ? D_RD : D_PTR; // R8
            if (!addr_ok)
              nxt_state = D_SKIP;
          end
        end
        D_PTR:
        begin
          nxt_sh = byte_in;
          if (byte_last)
          begin
            nxt_ptr = ptr_wr; // R6
            go = 1'b1;
            tgt = D_WR;
          end
        end
        D_WR:
        begin
          nxt_sh = byte_in;
          if (byte_last)
          begin
            if (ptr_ff[2:0] == MODE_REG_IDX)
              nxt_mode = byte_in; // R9 R22
            nxt_ptr = ptr_next(ptr_ff); // R23
            go = 1'b1;
            tgt = D_WR;
          end
        end
        D_ACK:
        begin
          nxt_state = after_ff;
          nxt_cnt = 3'h0;
          if (after_ff == D_RD)
            nxt_sh = reg_at(ptr_ff, mode_ff); // R10
        end
        D_RD:
        begin
          if (byte_last)
          begin
            nxt_ptr = ptr_next(ptr_ff); // R23
            if (spi_ff)
              nxt_sh = reg_at(nxt_ptr, mode_ff);
            else
              nxt_state = D_RACK;
          end
        end
        D_RACK:
        begin
          nxt_cnt = 3'h0;
          nxt_state = bit_in ? D_SKIP : D_RD;
          nxt_sh = reg_at(ptr_ff, mode_ff);
        end
      endcase
      if (go)
      begin
        nxt_cnt = 3'h0;
        if (spi_ff)
        begin
          nxt_state = tgt;
          if (tgt == D_RD)
            nxt_sh = reg_at(ptr_ff, mode_ff);
        end
        else
        begin
          // acknowledge slot comes first on the two-wire form
          nxt_state = D_ACK;
          nxt_after = tgt;
        end
      end
    end
    else if (drive_edge)
    begin
      // apart from start, stop and deselect, outputs change on the falling bit clock only
      nxt_oe = spi_ff | (state_ff == D_ACK) | (state_ff == D_RD); // R12
      nxt_out = (state_ff == D_RD) ? sh_ff[7] : 1'b0;
      if (state_ff == D_RD)
        nxt_sh = {sh_ff[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------
  wire [4:0] eff_mode = port_select ? mode_ff[MODE_MSB:MODE_LSB] // R18
                                    : mode_pins; // R21
  wire is_double = (eff_mode[4:2] == DOUBLE_CODE);
  wire is_quad = (eff_mode[4:2] == QUAD_CODE);
  wire is_single = ~eff_mode[4];
  wire muting = port_select ? ~mode_ff[MUTE_BIT] : mute_req;
  wire sleeping = port_select & mode_ff[PDN_BIT];
  wire quiet = init_busy | muting | sleeping | ratio_bad;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= D_IDLE;
      after_ff <= D_IDLE;
      cnt_ff <= 3'h0;
      sh_ff <= 8'h00;
      ptr_ff <= PTR_RESET; // R11
      mode_ff <= MODE_RESET; // R22
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
      mutei_ff <= 1'b0;
      fmt_ff <= 2'h0;
      dem_ff <= 2'h0;
      spd_ff <= SPD_SINGLE;
    end
    else
    begin
      state_ff <= nxt_state;
      after_ff <= nxt_after;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      mode_ff <= nxt_mode;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      mutei_ff <= ~quiet; // R1
      fmt_ff <= eff_mode[1:0]; // R14 R16 R17
      dem_ff <= is_single ? eff_mode[3:2] : DEEMPH_OFF; // R15
      spd_ff <= is_double ? SPD_DOUBLE : // R16
                is_quad ? SPD_QUAD : SPD_SINGLE; // R17
    end
  end

  // sleep-bit rising edge counts as a power-down cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      spi_ff <= 1'b0;
    else if (sel_fall)
      spi_ff <= 1'b1; // R2
    else if (pdn_rise)
      spi_ff <= 1'b0; // R2
  end

  assign lnk.dev_sd_o = out_ff;
  assign lnk.dev_sd_oe = oe_ff;
  assign format_sel = fmt_ff;
  assign deemph_sel = dem_ff;
  assign speed = spd_ff;
  assign mute_indicator_out = mutei_ff;
  assign cal_start = mode_ff[CAL_BIT];
  assign mute_active = muting;
  assign sleep_active = sleeping;
  assign spi_mode = spi_ff;
endmodule : dcpm_device

/* core/dcpm_host.sv */
// host-side controller driving the control link from AHB-Lite registers
`timescale 1ns/10ps

module dcpm_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  dcpm_if.host lnk
);
  import dcpm_pkg::*;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic a_wr_ff;
  logic [7:0] a_off_ff;
  logic [31:0] rdata_ff;
  logic [4:0] ctrl_ff;
  logic [7:0] ptr_ff;
  logic [7:0] wdat_ff;
  logic [7:0] rdat_ff;
  logic nack_ff;
  dcpm_hst_e hst_ff;

  // only whole-word transfers are taken
  wire take = hsel & htrans[1] & hready & (hsize == 3'h2);
  wire [7:0] off = haddr[7:0];
  wire idle = (hst_ff == H_IDLE);
  wire wr_ctrl = a_wr_ff & (a_off_ff == CTRL_OFF);
  wire go = wr_ctrl & hwdata[GO_BIT] & idle;
  wire [31:0] rd_mux =
    (off == CTRL_OFF) ? {27'h0, ctrl_ff[4:1], 1'b0} :
    (off == PTR_OFF) ? {24'h0, ptr_ff} :
    (off == WDAT_OFF) ? {24'h0, wdat_ff} :
    (off == RDAT_OFF) ? {24'h0, rdat_ff} :
    (off == STAT_OFF) ? {30'h0, nack_ff, ~idle} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_wr_ff <= 1'b0;
      a_off_ff <= 8'h00;
      rdata_ff <= 32'h0;
    end
    else
    begin
      a_wr_ff <= take & hwrite;
      a_off_ff <= off;
      if (take & ~hwrite)
        rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff <= CTRL_RESET;
      ptr_ff <= PTR_RESET;
      wdat_ff <= 8'h00;
    end
    else if (a_wr_ff)
    begin
      // mode bits are frozen while a frame runs
      if (wr_ctrl & idle)
        ctrl_ff <= {hwdata[4:1], 1'b0};
      if (a_off_ff == PTR_OFF)
        ptr_ff <= hwdata[7:0];
      if (a_off_ff == WDAT_OFF)
        wdat_ff <= hwdata[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  logic line;
  logic [3:0] div_ff;
  logic phase_ff;
  logic [4:0] nbit_ff;
  logic [1:0] stop_ff;
  logic [26:0] tx_ff;
  logic [26:0] ackm_ff;
  logic [8:0] rx_ff;
  logic clk_ff;
  logic sel_ff;
  logic cin_ff;
  logic sdoe_ff;

  dcpm_sync #(.W(1)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(lnk.sd_level),
    .q(line),
    .q_d()
  );

  wire g_rd = hwdata[RD_BIT];
  wire g_spi = hwdata[SPI_BIT];
  wire [7:0] addr8 = g_spi ? {SPI_CHIP_ADDR, g_rd} // R5
    : {I2C_ADDR_HI, hwdata[STRAP1_BIT], hwdata[STRAP0_BIT], g_rd}; // R7 R8
  wire [7:0] spi_ptr = {ptr_ff[PTR_AUTO_INCREMENT_BIT], 7'h01}; // R6
  wire [26:0] frame = g_spi
    ? (g_rd ? {addr8, 8'h00, 11'h000} : {addr8, spi_ptr, wdat_ff, 3'h0})
    : (g_rd ? {addr8, 1'b1, 9'h1ff, 9'h000} // R10
            : {addr8, 1'b1, ptr_ff, 1'b1, wdat_ff, 1'b1}); // R9
  wire [4:0] nbits = g_spi ? (g_rd ? NBIT_SPI_RD : NBIT_SPI_WR)
                           : (g_rd ? NBIT_I2C_RD : NBIT_I2C_WR);
  wire [26:0] ackm = g_spi ? 27'h0 : (g_rd ? ACKM_I2C_RD : ACKM_I2C_WR);
  wire tick = ~idle & (div_ff == HALF_LAST);
  wire run_spi = ctrl_ff[SPI_BIT];
  wire next_bit = tx_ff[FRAME_W-2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_ff <= 4'h0;
    else
      div_ff <= (idle | tick) ? 4'h0 : div_ff + 4'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hst_ff <= H_IDLE;
      phase_ff <= 1'b0;
      nbit_ff <= 5'h00;
      stop_ff <= 2'h0;
      tx_ff <= 27'h0;
      ackm_ff <= 27'h0;
      rx_ff <= 9'h000;
      rdat_ff <= 8'h00;
      nack_ff <= 1'b0;
      clk_ff <= 1'b1;
      sel_ff <= 1'b1;
      cin_ff <= 1'b0;
      sdoe_ff <= 1'b0;
    end
    else if (go)
    begin
      hst_ff <= H_START;
      tx_ff <= frame;
      ackm_ff <= ackm;
      nbit_ff <= nbits;
      nack_ff <= 1'b0;
      sel_ff <= ~g_spi & hwdata[STRAP0_BIT];
      sdoe_ff <= ~g_spi;
    end
    else if (idle)
    begin
      // straps held still between frames
      sel_ff <= run_spi | ctrl_ff[STRAP0_BIT]; // R20
      cin_ff <= ~run_spi & ctrl_ff[STRAP1_BIT];
      clk_ff <= 1'b1;
      sdoe_ff <= 1'b0;
    end
    else if (tick)
    begin
      unique case (hst_ff)
        H_START:
        begin
          hst_ff <= H_BITS;
          phase_ff <= 1'b0;
          clk_ff <= 1'b0;
          cin_ff <= run_spi ? tx_ff[FRAME_W-1] : cin_ff;
          sdoe_ff <= ~run_spi & ~tx_ff[FRAME_W-1];
        end
        H_BITS:
        begin
          phase_ff <= ~phase_ff;
          if (!phase_ff)
            clk_ff <= 1'b1;
          else
          begin
            rx_ff <= {rx_ff[7:0], line};
            if (ackm_ff[FRAME_W-1] & line)
              nack_ff <= 1'b1;
            tx_ff <= {tx_ff[FRAME_W-2:0], 1'b0};
            ackm_ff <= {ackm_ff[FRAME_W-2:0], 1'b0};
            nbit_ff <= nbit_ff - 5'h01;
            if (nbit_ff == 5'h01)
            begin
              hst_ff <= H_STOP;
              stop_ff <= 2'h0;
              clk_ff <= run_spi;
              sdoe_ff <= ~run_spi;
            end
            else
            begin
              clk_ff <= 1'b0;
              cin_ff <= run_spi ? next_bit : cin_ff;
              sdoe_ff <= ~run_spi & ~next_bit;
            end
          end
        end
        H_STOP:
        begin
          stop_ff <= stop_ff + 2'h1;
          rdat_ff <= run_spi ? rx_ff[7:0] : rx_ff[8:1];
          if (run_spi | (stop_ff == STOP_LAST))
          begin
            // two-wire frames keep the low strap; a bounce would latch SPI
            hst_ff <= H_IDLE;
            sel_ff <= run_spi | ctrl_ff[STRAP0_BIT]; // R2
          end
          else if (stop_ff == 2'h0)
            clk_ff <= 1'b1;
          else
            sdoe_ff <= 1'b0;
        end
        H_IDLE: hst_ff <= H_IDLE;
      endcase
    end
  end

  assign lnk.bit_clk = clk_ff;
  assign lnk.sel = sel_ff;
  assign lnk.ctl_in = cin_ff;
  assign lnk.host_sd_o = 1'b0;
  assign lnk.host_sd_oe = sdoe_ff;
endmodule : dcpm_host

/* dv/dcpm_properties.sv */
// assertions on the control link between host and converter port
`timescale 1ns/10ps

module dcpm_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bit_clk,
  input wire logic sel,
  input wire logic ctl_in,
  input wire logic dev_sd_o,
  input wire logic dev_sd_oe,
  input wire logic host_sd_o,
  input wire logic host_sd_oe,
  input wire logic sd_level
);
  logic clk_ff, sd_ff, sel_ff;
  logic [4:0] cnt_ff, nxt_cnt;
  wire rise = bit_clk & ~clk_ff;
  wire start_seen = bit_clk & clk_ff & sd_ff & ~sd_level;
  wire stop_seen = bit_clk & clk_ff & ~sd_ff & sd_level;
  // clock rises since the last start, stop or select change
  assign nxt_cnt = (start_seen | stop_seen | (sel ^ sel_ff)) ? 5'h00
    : cnt_ff + {4'h0, rise};
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {clk_ff, sd_ff, sel_ff, cnt_ff} <= 8'he0;
    else
      {clk_ff, sd_ff, sel_ff, cnt_ff} <= {bit_clk, sd_level, sel, nxt_cnt};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_start;
    bit_clk && $rose(host_sd_oe);
  endsequence
  sequence s_stop;
    bit_clk && $fell(host_sd_oe);
  endsequence
  sequence s_low_half;
    (!bit_clk)[*8] ##1 bit_clk;
  endsequence

  a_host_open_drain:
    assert property (host_sd_oe |-> !host_sd_o)
    else $error("host drove the data line high");
  a_sel_clk_idle:
    assert property ($changed(sel) |-> bit_clk && $past(bit_clk))
    else $error("select moved while the bit clock was low");
  a_clk_high_half:
    assert property ($rose(bit_clk) |-> bit_clk[*8])
    else $error("bit clock high half too short");
  a_clk_low_half:
    assert property ($fell(bit_clk) |-> s_low_half)
    else $error("bit clock low half wrong");
  a_start_clk_fall:
    assert property (s_start |-> ##[1:8] !bit_clk)
    else $error("no clock after start");
  a_stop_idle:
    assert property (s_stop |-> bit_clk[*8])
    else $error("link not quiet after stop");
  a_i2c_frame_len:
    assert property (stop_seen |-> cnt_ff inside {5'h00, 5'h13, 5'h1c})
    else $error("wrong bit count in two-wire frame");
  a_spi_frame_len:
    assert property ($rose(sel) |-> cnt_ff inside {5'h00, 5'h10, 5'h18})
    else $error("wrong bit count in select frame");
  a_dev_quiet_addr:
    assert property (rise && sel && dev_sd_oe |-> cnt_ff >= 5'h08)
    else $error("device drove during the address byte");
endmodule : dcpm_properties

/* dv/testbench.sv */
// self-checking bench for the converter control port and its host
`timescale 1ns/10ps

module testbench;
  import dcpm_pkg::*;
  typedef struct {
    logic [4:0] pins;
    logic [1:0] fmt;
    logic [1:0] dem;
    dcpm_speed_e spd;
  } dcpm_row_s;
  logic hclk = 0, hresetn = 0, hold = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, format_sel, deemph_sel;
  logic [2:0] hsize = 3'h2;
  logic [4:0] mode_pins = 0;
  logic hreadyout, hresp, port_select = 0, mute_req = 0, init_busy = 0;
  logic ratio_bad = 0, cal_done = 0, mute_indicator_out, cal_start;
  logic mute_active, sleep_active, spi_mode;
  dcpm_speed_e speed;
  int bad_count = 0, compares = 0;
  // device reset held apart so the host straps settle first
  wire dev_rstn = hresetn & ~hold;
  dcpm_row_s rows [11] = '{
    '{5'h00, 2'h0, 2'h0, SPD_SINGLE}, '{5'h05, 2'h1, 2'h1, SPD_SINGLE},
    '{5'h0a, 2'h2, 2'h2, SPD_SINGLE}, '{5'h0f, 2'h3, 2'h3, SPD_SINGLE},
    '{5'h10, 2'h0, 2'h3, SPD_SINGLE}, '{5'h1c, 2'h0, 2'h0, SPD_DOUBLE},
    '{5'h1d, 2'h1, 2'h0, SPD_DOUBLE}, '{5'h1f, 2'h3, 2'h0, SPD_DOUBLE},
    '{5'h19, 2'h1, 2'h0, SPD_QUAD}, '{5'h1a, 2'h2, 2'h0, SPD_QUAD},
    '{5'h1b, 2'h3, 2'h0, SPD_QUAD}};

  dcpm_if lnk ();
  dcpm_host dcpm_host_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .lnk(lnk.host));
  dcpm_device dcpm_device_inst (.hclk, .hresetn(dev_rstn),
    .lnk(lnk.dev), .port_select, .mode_pins, .mute_req, .init_busy,
    .ratio_bad, .cal_done, .format_sel, .deemph_sel, .speed,
    .mute_indicator_out, .cal_start, .mute_active, .sleep_active,
    .spi_mode);
  dcpm_properties dcpm_properties_inst (.hclk, .hresetn,
    .bit_clk(lnk.bit_clk), .sel(lnk.sel), .ctl_in(lnk.ctl_in),
    .dev_sd_o(lnk.dev_sd_o), .dev_sd_oe(lnk.dev_sd_oe),
    .host_sd_o(lnk.host_sd_o), .host_sd_oe(lnk.host_sd_oe),
    .sd_level(lnk.sd_level));

  initial
  begin
    forever #5 hclk = ~hclk;
  end

  task conclude;
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task wt(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : wt

  // one single word transfer; r holds read data
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rdchk

  // start a frame and poll busy until it is over
  task xfer(input logic [7:0] c, input logic [7:0] d);
    ahb(1'b1, WDAT_OFF, {24'h0, d});
    ahb(1'b1, CTRL_OFF, {24'h0, c});
    do ahb(1'b0, STAT_OFF, 32'h0); while (r[0] !== 1'b0);
    wt(6);
  endtask : xfer

  initial
  begin
    #400000;
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    chk(mute_indicator_out, 0);
    rdchk(PTR_OFF, 32'h01);
    ahb(1'b1, 8'h14, 32'hffffffff);
    rdchk(8'h14, 32'h0);
    ahb(1'b1, CTRL_OFF, 32'h08);
    wt(4);
    hold <= 1'b0;
    wt(8);
    chk(spi_mode, 0);
    foreach (rows[i])
    begin
      @(posedge hclk);
      mode_pins <= rows[i].pins;
      mute_req <= rows[i].pins[0];
      wt(6);
      chk(format_sel, rows[i].fmt);
      chk(speed, rows[i].spd);
      chk(mute_active, rows[i].pins[0]);
      if (rows[i].spd == SPD_SINGLE)
        chk(deemph_sel, rows[i].dem);
    end
    @(posedge hclk);
    mode_pins <= 5'h00;
    port_select <= 1'b1;
    xfer(8'h0b, 8'h00);
    rdchk(RDAT_OFF, MODE_RESET);
    xfer(8'h09, 8'h5e);
    rdchk(STAT_OFF, 32'h0);
    chk(format_sel, 3);
    chk(deemph_sel, 3);
    chk(speed, SPD_SINGLE);
    chk(mute_indicator_out, 1);
    xfer(8'h0b, 8'h00);
    rdchk(RDAT_OFF, 32'h5e);
    for (int i = 1; i < 3; i++)
    begin
      @(posedge hclk);
      {init_busy, ratio_bad} <= i[1:0];
      wt(6);
      chk(mute_indicator_out, 0);
      {init_busy, ratio_bad} <= 2'h0;
      wt(6);
      chk(mute_indicator_out, 1);
    end
    ahb(1'b1, PTR_OFF, 32'h81);
    xfer(8'h09, 8'h1c);
    chk(mute_active, 1);
    chk(mute_indicator_out, 0);
    xfer(8'h0b, 8'h00);
    rdchk(RDAT_OFF, 32'h0);
    ahb(1'b1, PTR_OFF, 32'h01);
    xfer(8'h09, 8'hde);
    chk(cal_start, 1);
    @(posedge hclk);
    cal_done <= 1'b1;
    @(posedge hclk);
    cal_done <= 1'b0;
    wt(6);
    chk(cal_start, 0);
    xfer(8'h05, 8'h58);
    chk(spi_mode, 1);
    chk(format_sel, 0);
    xfer(8'h07, 8'h00);
    rdchk(RDAT_OFF, 32'h58);
    ahb(1'b1, CTRL_OFF, 32'h08);
    wt(6);
    chk(spi_mode, 1);
    xfer(8'h05, 8'h59);
    chk(spi_mode, 0);
    chk(sleep_active, 1);
    chk(mute_indicator_out, 0);
    xfer(8'h05, 8'h58);
    chk(spi_mode, 1);
    @(posedge hclk);
    hresetn <= 1'b0;
    wt(3);
    chk(spi_mode, 0);
    chk(mute_indicator_out, 0);
    conclude();
  end
endmodule : testbench
